//--- src/hid_inrush_detector.sv
// Harmonic inrush detector: per-phase second-harmonic restraint decision,
// general flag, on/off event, AHB-Lite register slave and interrupt.
// Assumes measurements and blocking input come from logic on hclk.
//
// Summary of operation
// - Per phase, compare second harmonic to fundamental as percent; threshold 5..50, default 15.
// - Phase flags inrush only while fundamental exceeds sensitivity 20..100, default 30.
// - Sensitivity is a percentage of the CT nominal current, not the signal.
// - While blocking input is high, all inrush indications are suppressed.
// - One separate inrush flag per phase, reflecting only that phase.
// - General flag is high whenever any phase flag is high.
// - Event carries on when general flag rises, off when it falls.
// - Phases evaluated independently with shared threshold settings.
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
module hid_inrush_detector
  import hid_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Measurements from the Fourier stage
  input wire hid_meas_t [HID_NPH-1:0] phase_meas,
  input wire logic meas_valid,
  // Blocking input
  input wire logic inrush_block_in,
  // Detection outputs
  output logic inrush_phase_a,
  output logic inrush_phase_b,
  output logic inrush_phase_c,
  output logic inrush_any_phase,
  output hid_event_t harmonic_restraint_event,
  // Interrupt
  output logic irq
);

  // Register state
  logic en_ff;
  logic [6:0] second_harmonic_ratio_threshold_ff;
  logic [6:0] fundamental_sensitivity_threshold_ff;
  logic [HID_MAG_W-1:0] nominal_ff;
  logic [1:0] irq_status_ff;
  logic [1:0] irq_enable_ff;
  logic irq_ff;

  // Bus state
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;

  // Detection state
  logic [HID_NPH-1:0] phase_ff;
  logic any_ff;
  hid_event_t event_ff;

  // Address phase decode
  wire addr_phase = hsel && hready && (htrans == HID_HTRANS_NONSEQ);
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hi_zero = (haddr[31:8] == 24'h000000);

  // Data phase write strobes
  wire wr_ctrl = wr_pend_ff && (wr_addr_ff == HID_OFS_CTRL);
  wire wr_ratio = wr_pend_ff && (wr_addr_ff == HID_OFS_RATIO);
  wire wr_sens = wr_pend_ff && (wr_addr_ff == HID_OFS_SENS);
  wire wr_nom = wr_pend_ff && (wr_addr_ff == HID_OFS_NOMINAL);
  wire wr_ien = wr_pend_ff && (wr_addr_ff == HID_OFS_IRQ_ENABLE);
  wire wr_iclr = wr_pend_ff && (wr_addr_ff == HID_OFS_IRQ_CLEAR);

  // Threshold writes clamp to the settable range
  wire [6:0] wd7 = hwdata[6:0];
  wire wd7_ovf = (hwdata[31:7] != 25'h0);
  wire [6:0] ratio_wr =
    (wd7_ovf || wd7 > HID_RATIO_MAX) ? HID_RATIO_MAX :
    (wd7 < HID_RATIO_MIN) ? HID_RATIO_MIN : wd7;
  wire [6:0] sens_wr =
    (wd7_ovf || wd7 > HID_SENS_MAX) ? HID_SENS_MAX :
    (wd7 < HID_SENS_MIN) ? HID_SENS_MIN : wd7;

  // Sensitivity level from CT nominal, scaled by 100 on both sides
  wire [22:0] sens_level = 23'(fundamental_sensitivity_threshold_ff) * 23'(nominal_ff);

  // Per-phase decision, shared thresholds
  wire [HID_NPH-1:0] det;
  genvar gi;
  generate
    for (gi = 0; gi < HID_NPH; gi++) begin : g_phase
      wire [22:0] harm_x100 = 23'(phase_meas[gi].harm2) * 23'(HID_PCT_SCALE);
      wire [22:0] fund_xr =
        23'(phase_meas[gi].fund) * 23'(second_harmonic_ratio_threshold_ff);
      wire [22:0] fund_x100 = 23'(phase_meas[gi].fund) * 23'(HID_PCT_SCALE);
      wire ratio_hit = harm_x100 > fund_xr;
      wire level_ok = fund_x100 > sens_level;
      assign det[gi] = ratio_hit && level_ok;
    end
  endgenerate

  // Flag next state
  wire suppress = inrush_block_in || !en_ff;
  wire [HID_NPH-1:0] nxt_phase =
    suppress ? {HID_NPH{1'b0}} :
    meas_valid ? det : phase_ff;
  wire nxt_any = |nxt_phase;
  wire any_rise = nxt_any && !any_ff;
  wire any_fall = !nxt_any && any_ff;

  // Interrupt status: set wins over clear
  wire [1:0] irq_set;
  assign irq_set[HID_IRQ_ON_BIT] = any_rise;
  assign irq_set[HID_IRQ_OFF_BIT] = any_fall;
  wire [1:0] irq_clr = wr_iclr ? hwdata[1:0] : 2'b00;
  wire [1:0] nxt_irq_status = irq_set | (irq_status_ff & ~irq_clr);
  wire nxt_irq = |(nxt_irq_status & irq_enable_ff);

  // Read select; unmapped offsets and the clear register read zero
  wire rs_ctrl = a_hi_zero && (a_ofs == HID_OFS_CTRL);
  wire rs_ratio = a_hi_zero && (a_ofs == HID_OFS_RATIO);
  wire rs_sens = a_hi_zero && (a_ofs == HID_OFS_SENS);
  wire rs_nom = a_hi_zero && (a_ofs == HID_OFS_NOMINAL);
  wire rs_flags = a_hi_zero && (a_ofs == HID_OFS_FLAGS);
  wire rs_istat = a_hi_zero && (a_ofs == HID_OFS_IRQ_STATUS);
  wire rs_ien = a_hi_zero && (a_ofs == HID_OFS_IRQ_ENABLE);

  // Read words
  wire [31:0] ctrl_word = 32'(en_ff) << HID_CTRL_EN_BIT;
  wire [31:0] flags_word = 32'(phase_ff) | (32'(any_ff) << HID_FLAG_ANY_BIT) |
    (32'(inrush_block_in) << HID_FLAG_BLK_BIT);
  wire [31:0] rd_mux =
    rs_ctrl ? ctrl_word :
    rs_ratio ? {25'h0, second_harmonic_ratio_threshold_ff} :
    rs_sens ? {25'h0, fundamental_sensitivity_threshold_ff} :
    rs_nom ? {16'h0, nominal_ff} :
    rs_flags ? flags_word :
    rs_istat ? {30'h0, irq_status_ff} :
    rs_ien ? {30'h0, irq_enable_ff} :
    32'h00000000;
  wire [31:0] nxt_hrdata = rd_take ? rd_mux : 32'h00000000;

  // Write pending for the data phase of an accepted write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take && a_hi_zero;
    end
  end

  // Offset of the pending write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_ff <= 8'h00;
    end else begin
      wr_addr_ff <= a_ofs;
    end
  end

  // Read data stands for the data phase only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Zero wait states; low only while in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  // Write data fields
  wire en_wd = hwdata[HID_CTRL_EN_BIT];
  wire [HID_MAG_W-1:0] nom_wd = hwdata[HID_MAG_W-1:0];
  wire [1:0] ien_wd = hwdata[1:0];

  // Operation enable, off after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= 1'b0;
    end else if (wr_ctrl) begin
      en_ff <= en_wd;
    end
  end

  // Ratio setting, clamped on write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_harmonic_ratio_threshold_ff <= HID_RATIO_RST;
    end else if (wr_ratio) begin
      second_harmonic_ratio_threshold_ff <= ratio_wr;
    end
  end

  // Sensitivity setting, clamped on write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fundamental_sensitivity_threshold_ff <= HID_SENS_RST;
    end else if (wr_sens) begin
      fundamental_sensitivity_threshold_ff <= sens_wr;
    end
  end

  // CT nominal in magnitude units
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nominal_ff <= HID_NOMINAL_RST;
    end else if (wr_nom) begin
      nominal_ff <= nom_wd;
    end
  end

  // Interrupt enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_ff <= 2'b00;
    end else if (wr_ien) begin
      irq_enable_ff <= ien_wd;
    end
  end

  // Phase flags, cleared by blocking or disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= {HID_NPH{1'b0}};
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // General flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_ff <= 1'b0;
    end else begin
      any_ff <= nxt_any;
    end
  end

  // Event: one-cycle pulse, value follows the general flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_ff <= '0;
    end else begin
      event_ff.pulse <= any_rise || any_fall;
      event_ff.value <= nxt_any;
    end
  end

  // Sticky interrupt status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= 2'b00;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // Level interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Outputs
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign inrush_phase_a = phase_ff[0];
  assign inrush_phase_b = phase_ff[1];
  assign inrush_phase_c = phase_ff[2];
  assign inrush_any_phase = any_ff;
  assign harmonic_restraint_event = event_ff;
  assign irq = irq_ff;

endmodule : hid_inrush_detector

//--- src/hid_pkg.sv
// Package for the harmonic inrush detector: register map, field layouts,
// reset values and the measurement carrier type.
// Assumes 32-bit AHB-Lite data and 16-bit magnitude words.
package hid_pkg;
  localparam int HID_MAG_W = 16;
  localparam int HID_NPH = 3;
  // Register byte offsets
  localparam logic [7:0] HID_OFS_CTRL = 8'h00;
  localparam logic [7:0] HID_OFS_RATIO = 8'h04;
  localparam logic [7:0] HID_OFS_SENS = 8'h08;
  localparam logic [7:0] HID_OFS_NOMINAL = 8'h0C;
  localparam logic [7:0] HID_OFS_FLAGS = 8'h10;
  localparam logic [7:0] HID_OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] HID_OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] HID_OFS_IRQ_CLEAR = 8'h1C;
  // Field positions
  localparam int HID_CTRL_EN_BIT = 0;
  localparam int HID_FLAG_ANY_BIT = 3;
  localparam int HID_FLAG_BLK_BIT = 4;
  localparam int HID_IRQ_ON_BIT = 0;
  localparam int HID_IRQ_OFF_BIT = 1;
  // Threshold ranges and reset values
  localparam logic [6:0] HID_RATIO_MIN = 7'h05;
  localparam logic [6:0] HID_RATIO_MAX = 7'h32;
  localparam logic [6:0] HID_RATIO_RST = 7'h0F;
  localparam logic [6:0] HID_SENS_MIN = 7'h14;
  localparam logic [6:0] HID_SENS_MAX = 7'h64;
  localparam logic [6:0] HID_SENS_RST = 7'h1E;
  localparam logic [6:0] HID_PCT_SCALE = 7'h64;
  localparam logic [HID_MAG_W-1:0] HID_NOMINAL_RST = 16'h1000;
  // AHB transfer type
  localparam logic [1:0] HID_HTRANS_NONSEQ = 2'h2;
  // One phase's magnitudes from the Fourier stage
  typedef struct packed {
    logic [HID_MAG_W-1:0] fund;
    logic [HID_MAG_W-1:0] harm2;
  } hid_meas_t;
  // General flag change event
  typedef struct packed {
    logic pulse;
    logic value;
  } hid_event_t;
endpackage : hid_pkg

//--- verif/hid_fourier_model.sv
// Fourier stage model: one sample per request, valid for one cycle.
// Assumes the bench raises load for one hclk cycle per sample.
`timescale 1ns/1ns
module hid_fourier_model
  import hid_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench request
  input wire logic load,
  input wire hid_meas_t [HID_NPH-1:0] smp,
  // To the detector
  output hid_meas_t [HID_NPH-1:0] phase_meas,
  output logic meas_valid
);
  // Data scrambled outside the valid cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_meas <= '0;
      meas_valid <= 1'b0;
    end else begin
      phase_meas <= load ? smp : ~phase_meas;
      meas_valid <= load;
    end
  end
endmodule : hid_fourier_model

//--- verif/hid_inrush_asserts.sv
// Checker on the detector ports: flags, blocking and event.
// Assumes binding into hid_inrush_detector.
`timescale 1ns/1ns
module hid_inrush_asserts
  import hid_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs watched
  input wire hid_meas_t [HID_NPH-1:0] phase_meas,
  input wire logic meas_valid,
  input wire logic inrush_block_in,
  // Results
  input wire logic inrush_phase_a,
  input wire logic inrush_phase_b,
  input wire logic inrush_phase_c,
  input wire logic inrush_any_phase,
  input wire hid_event_t harmonic_restraint_event
);
  wire [2:0] fl = {inrush_phase_c, inrush_phase_b, inrush_phase_a};
  wire [1:0] ev = harmonic_restraint_event;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_any_or: assert property (inrush_any_phase == |fl)
    else $error("general flag");
  a_block_clear: assert property (inrush_block_in |=> fl == 3'h0)
    else $error("block");
  a_no_rise: assert property (!meas_valid |=> (fl & ~$past(fl)) == 3'h0)
    else $error("rise");
  a_ev_on: assert property ($rose(inrush_any_phase) |-> ev == 2'h3)
    else $error("on");
  a_ev_off: assert property ($fell(inrush_any_phase) |-> ev == 2'h2)
    else $error("off");
  a_ev_cause: assert property (ev[1] |-> $changed(inrush_any_phase))
    else $error("pulse");
  a_ev_value: assert property (ev[0] == inrush_any_phase)
    else $error("value");
  a_ratio_zero: assert property (
    meas_valid && phase_meas[0].harm2 == 16'h0 |=> !inrush_phase_a) else $error("ratio");
  a_sens_zero: assert property (
    meas_valid && phase_meas[1].fund == 16'h0 |=> !inrush_phase_b) else $error("sens");
  c_on: cover property ($rose(inrush_any_phase));
  c_off: cover property ($fell(inrush_any_phase));
  c_block: cover property (inrush_block_in && meas_valid);
endmodule : hid_inrush_asserts
bind hid_inrush_detector hid_inrush_asserts u_asserts (.hclk(hclk), .hresetn(hresetn),
  .phase_meas(phase_meas), .meas_valid(meas_valid), .inrush_block_in(inrush_block_in),
  .inrush_phase_a(inrush_phase_a), .inrush_phase_b(inrush_phase_b),
  .inrush_phase_c(inrush_phase_c), .inrush_any_phase(inrush_any_phase),
  .harmonic_restraint_event(harmonic_restraint_event));

//--- verif/tb_top.sv
// Bench: register access over AHB-Lite, corner and random samples, interrupt.
// Assumes the detector and the Fourier model share hclk.
`timescale 1ns/1ns
module tb_top
  import hid_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, load = 1'b0, blk = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hresp, valid, a, b, c, any, irq, pany = 1'b0, en = 1'b0;
  logic [6:0] ratio = HID_RATIO_RST, sens = HID_SENS_RST;
  logic [2:0] ef;
  wire hready;
  hid_meas_t [HID_NPH-1:0] smp = '0, meas;
  hid_event_t ev;
  int err_total = 0, tests_run = 0;
  hid_inrush_detector DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .phase_meas(meas),
    .meas_valid(valid), .inrush_block_in(blk), .inrush_phase_a(a), .inrush_phase_b(b),
    .inrush_phase_c(c), .inrush_any_phase(any), .harmonic_restraint_event(ev), .irq(irq));
  hid_fourier_model u_src (.hclk(hclk), .hresetn(hresetn), .load(load), .smp(smp),
    .phase_meas(meas), .meas_valid(valid));
  initial forever #5 hclk = ~hclk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, HID_HTRANS_NONSEQ, 24'h0, ad};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask : bus
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk("hrdata", rd, e);
  endtask : rchk
  function automatic logic hit(input logic [15:0] f, input logic [15:0] h);
    return ({16'h0, h} * 32'h64 > {16'h0, f} * ratio) && ({16'h0, f} * 32'h64 > sens * 32'h100);
  endfunction : hit
  task automatic go(input logic bb);
    @(posedge hclk);
    load <= 1'b1;
    blk <= bb;
    @(posedge hclk);
    load <= 1'b0;
    #1;
    if (bb) begin
      chk("block event", ev, {pany, 1'b0});
      pany = 1'b0;
    end
    @(posedge hclk);
    #1;
    for (int k = 0; k < HID_NPH; k++) ef[k] = hit(smp[k].fund, smp[k].harm2) & !bb & en;
    chk("phase flags", {c, b, a}, ef);
    chk("general flag", any, |ef);
    chk("event", ev, {(|ef) != pany, |ef});
    pany = |ef;
  endtask : go
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #300000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h1122a7a8));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(HID_OFS_CTRL, 32'h0);
    rchk(HID_OFS_RATIO, 32'hF);
    rchk(HID_OFS_SENS, 32'h1E);
    rchk(HID_OFS_NOMINAL, 32'h1000);
    rchk(8'h40, 32'h0);
    bus(1'b1, HID_OFS_RATIO, 32'h7F);
    rchk(HID_OFS_RATIO, 32'h32);
    bus(1'b1, HID_OFS_SENS, 32'h0);
    rchk(HID_OFS_SENS, 32'h14);
    bus(1'b1, HID_OFS_RATIO, 32'hF);
    bus(1'b1, HID_OFS_SENS, 32'h1E);
    bus(1'b1, HID_OFS_NOMINAL, 32'h100);
    bus(1'b1, HID_OFS_IRQ_ENABLE, 32'h3);
    smp = {32'h0C8001E1, 32'h00000100, 32'h0C8001E0};
    go(1'b0);
    bus(1'b1, HID_OFS_CTRL, 32'h1);
    en = 1'b1;
    go(1'b0);
    go(1'b1);
    smp = {32'h004D0100, 32'h004C0100, 32'h10000000};
    go(1'b0);
    for (int i = 0; i < 60; i++) begin
      if (i % 12 == 0) begin
        ratio = 7'(32'h5 + $urandom % 32'h2E);
        sens = 7'(32'h14 + $urandom % 32'h51);
        bus(1'b1, HID_OFS_RATIO, {25'h0, ratio});
        bus(1'b1, HID_OFS_SENS, {25'h0, sens});
      end
      for (int k = 0; k < HID_NPH; k++) begin
        smp[k].fund = 16'($urandom % 32'h400);
        smp[k].harm2 = 16'($urandom % (smp[k].fund / 2 + 1));
      end
      go($urandom % 32'h6 == 0);
    end
    go(1'b1);
    bus(1'b1, HID_OFS_IRQ_CLEAR, 32'h3);
    rchk(HID_OFS_IRQ_STATUS, 32'h0);
    chk("irq", irq, 1'b0);
    ratio = 7'hF;
    sens = 7'h1E;
    bus(1'b1, HID_OFS_RATIO, 32'hF);
    bus(1'b1, HID_OFS_SENS, 32'h1E);
    smp = {32'h0C8001E1, 32'h00000100, 32'h0C8001E0};
    go(1'b0);
    rchk(HID_OFS_IRQ_STATUS, 32'h1);
    chk("irq", irq, 1'b1);
    bus(1'b1, HID_OFS_IRQ_ENABLE, 32'h0);
    rchk(HID_OFS_FLAGS, 32'hC);
    chk("irq", irq, 1'b0);
    bus(1'b1, HID_OFS_IRQ_CLEAR, 32'h3);
    rchk(HID_OFS_IRQ_STATUS, 32'h0);
    print_verdict();
  end
endmodule : tb_top
